// [hdl/fps_pkg.sv]
// Functional notes
// - the input clock is divided by four into four non-overlapping phases forming one instruction cycle.
// - the program counter advances at phase one of every cycle, which starts a fetch.
// - the addressed program word is read during the fetch cycle and captured at phase four.
// - the fetched instruction stands in the instruction register from phase one and executes in phases two to four.
// - the data memory operand is read in phase two and the result is written in phase four.
// - the next fetch overlaps the current execution, so a plain instruction takes one cycle.
// - a program counter change discards the instruction already fetched, so a branch takes two cycles.
// - the program counter is 9 bits wide, a logical space of 512 twelve-bit words.
// - only 256 words exist, and higher fetch addresses wrap by ignoring the upper bit.
// - after any reset execution begins at address zero.
// - with the shared pin configured as external reset, a low level holds the device in reset.
// - every instruction word is 12 bits wide.
package fps_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int FPS_PC_W = 9;
  localparam int FPS_MEM_AW = 8;
  localparam int FPS_WORD_W = 12;
  localparam int FPS_MEM_WORDS = 256;

  // ----------------------------------------------------------------
  // reset values and fixed addresses
  // ----------------------------------------------------------------
  localparam logic [FPS_PC_W-1:0] FPS_RESET_VECTOR = 9'h000;
  localparam logic [FPS_PC_W-1:0] FPS_PC_STEP = 9'h001;
  localparam logic [FPS_MEM_AW-1:0] FPS_CAL_ADDR = 8'hff;
  localparam logic [FPS_WORD_W-1:0] FPS_IR_RESET = 12'h000;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_ONE = 4'h1,
    PH_TWO = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR = 4'h8
  } fps_phase_state_t;

  localparam fps_phase_state_t FPS_PHASE_RESET = PH_FOUR;

  typedef struct packed {
    logic phase_one;
    logic phase_two;
    logic phase_three;
    logic phase_four;
  } fps_phase_t;

  typedef struct packed {
    logic rd;
    logic wr;
  } fps_dmem_strobe_t;

  typedef struct packed {
    logic we;
    logic [FPS_MEM_AW-1:0] addr;
    logic [FPS_WORD_W-1:0] data;
  } fps_prog_wr_t;

endpackage

// [hdl/fps_prog_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module fps_prog_mem
  import fps_pkg::*;
#(
  parameter int AW = FPS_MEM_AW,
  parameter int DW = FPS_WORD_W
) (
  input wire logic mclk_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out,
  input wire fps_prog_wr_t wr_in
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_data_q;

  // array left unreset: contents belong to the programmer, not to reset
  always_ff @(posedge mclk_in) begin
    if (wr_in.we) begin
      mem_q[wr_in.addr] <= wr_in.data;
    end
    rd_data_q <= mem_q[rd_addr_in];
  end

  assign rd_data_out = rd_data_q;

endmodule
`default_nettype wire

// [hdl/fps_core.sv]
`timescale 1ns/1ns
`default_nettype none
module fps_core
  import fps_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic external_reset_n_in,
  input wire logic ext_reset_enable_in,
  input wire logic pc_load_in,
  input wire logic [FPS_PC_W-1:0] pc_target_in,
  input wire fps_prog_wr_t prog_wr_in,
  output var fps_phase_t phase_out,
  output logic [FPS_WORD_W-1:0] instruction_register_out,
  output logic instr_valid_out,
  output logic [FPS_PC_W-1:0] program_counter_out,
  output var fps_dmem_strobe_t dmem_strobe_out
);

  // ----------------------------------------------------------------
  // reset
  // ----------------------------------------------------------------
  logic rst_raw_n;
  logic rst_meta_q;
  logic rst_n_q;

  assign rst_raw_n = rstn_in & ~(ext_reset_enable_in & ~external_reset_n_in);

  always_ff @(posedge mclk_in or negedge rst_raw_n) begin
    if (!rst_raw_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  fps_phase_state_t phase_q;
  fps_phase_state_t phase_d;

  always_comb begin
    unique case (phase_q)
      PH_ONE: phase_d = PH_TWO;
      PH_TWO: phase_d = PH_THREE;
      PH_THREE: phase_d = PH_FOUR;
      PH_FOUR: phase_d = PH_ONE;
      default: phase_d = PH_ONE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= FPS_PHASE_RESET;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------------------------------
  // fetch and pipeline
  // ----------------------------------------------------------------
  logic [FPS_PC_W-1:0] program_counter_q;
  logic [FPS_PC_W-1:0] program_counter_d;
  logic [FPS_PC_W-1:0] fetch_addr_q;
  logic [FPS_PC_W-1:0] fetch_addr_d;
  logic fetch_live_q;
  logic fetch_live_d;
  logic [FPS_WORD_W-1:0] instruction_register_q;
  logic [FPS_WORD_W-1:0] instruction_register_d;
  logic ir_valid_q;
  logic ir_valid_d;
  logic [FPS_WORD_W-1:0] mem_rdata;
  logic cycle_end;
  logic branch;

  function automatic logic [FPS_PC_W-1:0] pc_next(input logic [FPS_PC_W-1:0] a);
    pc_next = a + FPS_PC_STEP;
  endfunction

  assign cycle_end = (phase_q == PH_FOUR);
  // only a valid instruction may steer the counter; a flushed slot cannot branch
  assign branch = cycle_end & ir_valid_q & pc_load_in;

  always_comb begin
    program_counter_d = program_counter_q;
    fetch_addr_d = fetch_addr_q;
    fetch_live_d = fetch_live_q;
    instruction_register_d = instruction_register_q;
    ir_valid_d = ir_valid_q;
    if (cycle_end) begin
      // the new cycle opens with phase one: start the next fetch
      fetch_live_d = 1'b1;
      if (branch) begin
        fetch_addr_d = pc_target_in;
        program_counter_d = pc_next(pc_target_in);
      end else begin
        fetch_addr_d = program_counter_q;
        program_counter_d = pc_next(program_counter_q);
      end
      instruction_register_d = mem_rdata;
      ir_valid_d = fetch_live_q & ~branch;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      program_counter_q <= FPS_RESET_VECTOR;
      fetch_addr_q <= FPS_RESET_VECTOR;
      fetch_live_q <= 1'b0;
      instruction_register_q <= FPS_IR_RESET;
      ir_valid_q <= 1'b0;
    end else begin
      program_counter_q <= program_counter_d;
      fetch_addr_q <= fetch_addr_d;
      fetch_live_q <= fetch_live_d;
      instruction_register_q <= instruction_register_d;
      ir_valid_q <= ir_valid_d;
    end
  end

  // upper counter bit is dropped, so fetches above the array wrap
  fps_prog_mem #(
    .AW(FPS_MEM_AW),
    .DW(FPS_WORD_W)
  ) u_prog_mem (
    .mclk_in(mclk_in),
    .rd_addr_in(fetch_addr_q[FPS_MEM_AW-1:0]),
    .rd_data_out(mem_rdata),
    .wr_in(prog_wr_in)
  );

  // ----------------------------------------------------------------
  // data memory strobes
  // ----------------------------------------------------------------
  fps_dmem_strobe_t dmem_q;
  fps_dmem_strobe_t dmem_d;

  always_comb begin
    // valid is stable across phases two to four, so registered strobes line up
    dmem_d.rd = (phase_d == PH_TWO) & ir_valid_d;
    dmem_d.wr = (phase_d == PH_FOUR) & ir_valid_d;
  end

  always_ff @(posedge mclk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dmem_q <= '0;
    end else begin
      dmem_q <= dmem_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign phase_out.phase_one = phase_q[0];
  assign phase_out.phase_two = phase_q[1];
  assign phase_out.phase_three = phase_q[2];
  assign phase_out.phase_four = phase_q[3];
  assign instruction_register_out = instruction_register_q;
  assign instr_valid_out = ir_valid_q;
  assign program_counter_out = program_counter_q;
  assign dmem_strobe_out = dmem_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_rotate;
    phase_q == PH_TWO ##1 phase_q == PH_THREE ##1 phase_q == PH_FOUR ##1 phase_q == PH_ONE;
  endsequence

  sequence s_flushed_then_live;
    !ir_valid_q [*4] ##1 ir_valid_q;
  endsequence

  AST_PHASE_ROTATE: assert property (
    phase_q == PH_ONE |=> s_rotate)
    else $error("phase order broken");

  AST_PHASE_ONEHOT: assert property (
    $onehot(phase_q))
    else $error("phase not one-hot");

  // sampled rst_n_q keeps out the edge that lifts reset, where registers still hold reset
  AST_PC_STEP: assert property (
    (rst_n_q && cycle_end && !branch) |=> program_counter_q == pc_next($past(program_counter_q))
      && fetch_addr_q == $past(program_counter_q) && phase_q == PH_ONE)
    else $error("counter did not step at phase one");

  AST_IR_CAPTURE: assert property (
    (rst_n_q && cycle_end) |=> instruction_register_q == $past(mem_rdata))
    else $error("instruction not captured at phase four");

  AST_IR_HELD: assert property (
    phase_q == PH_ONE |=> $stable(instruction_register_q) [*3])
    else $error("instruction changed during execution");

  AST_DMEM_READ: assert property (
    dmem_q.rd |-> phase_q == PH_TWO && ir_valid_q ##2 dmem_q.wr)
    else $error("operand read outside phase two");

  AST_DMEM_WRITE: assert property (
    (phase_q == PH_FOUR && ir_valid_q) |-> dmem_q.wr)
    else $error("destination write missing in phase four");

  AST_NO_BUBBLE: assert property (
    (cycle_end && ir_valid_q && !pc_load_in) |=> ir_valid_q)
    else $error("bubble without branch");

  AST_BRANCH_FLUSH: assert property (
    branch |=> fetch_addr_q == $past(pc_target_in) ##0 s_flushed_then_live)
    else $error("branch did not flush exactly one slot");

  AST_RESET_VECTOR: assert property (
    $rose(rst_n_q) |-> !ir_valid_q ##1 fetch_addr_q == FPS_RESET_VECTOR ##4 ir_valid_q)
    else $error("reset vector fetch wrong");

endmodule
`default_nettype wire

// [tb/fps_prog_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fps_prog_model
  import fps_pkg::*;
#(
  // arbitrary stand-in for the factory calibration word
  parameter logic [FPS_WORD_W-1:0] CAL_WORD = 12'ha5c
) (
  input wire logic mclk_in,
  output var fps_prog_wr_t prog_wr_out
);
  // ----------------------------------------------------------------
  // programming side of the program memory
  // ----------------------------------------------------------------
  logic cal_written;

  initial begin
    prog_wr_out = '0;
    cal_written = 1'b0;
  end

  function automatic logic [FPS_WORD_W-1:0] word_at(input logic [FPS_MEM_AW-1:0] a);
    return (a == FPS_CAL_ADDR) ? CAL_WORD : {4'h5, a};
  endfunction

  // one write per falling edge, held over the rising edge that takes it;
  // the calibration word is written once and then left alone
  task automatic load_all();
    for (int a = 0; a < FPS_MEM_WORDS; a++) begin
      @(negedge mclk_in);
      prog_wr_out.addr = a[FPS_MEM_AW-1:0];
      prog_wr_out.data = word_at(a[FPS_MEM_AW-1:0]);
      prog_wr_out.we = !(prog_wr_out.addr == FPS_CAL_ADDR && cal_written);
    end
    @(negedge mclk_in);
    cal_written = 1'b1;
    prog_wr_out.we = 1'b0;
    // released bus: show junk rather than the last value
    prog_wr_out.addr = ~prog_wr_out.addr;
    prog_wr_out.data = ~prog_wr_out.data;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top import fps_pkg::*;;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ext_pin_n = 1'b1;
  logic ext_en = 1'b0;
  logic pc_load = 1'b0;
  logic [FPS_PC_W-1:0] pc_target = 9'h000;
  fps_prog_wr_t prog_wr;
  fps_phase_t phase;
  logic [FPS_WORD_W-1:0] ir;
  logic valid;
  logic [FPS_PC_W-1:0] pc;
  fps_dmem_strobe_t strobe;
  logic [7:0] ea = 8'h00;
  int mismatches = 0;
  int samples_checked = 0;

  always #20 mclk_in = ~mclk_in;

  fps_prog_model PM (.mclk_in(mclk_in), .prog_wr_out(prog_wr));

  fps_core DUT (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .external_reset_n_in(ext_pin_n),
    .ext_reset_enable_in(ext_en),
    .pc_load_in(pc_load),
    .pc_target_in(pc_target),
    .prog_wr_in(prog_wr),
    .phase_out(phase),
    .instruction_register_out(ir),
    .instr_valid_out(valid),
    .program_counter_out(pc),
    .dmem_strobe_out(strobe)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic sync_p1();
    int n;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (phase.phase_one !== 1'b1 && n < 8);
    chk(16'(phase), 16'h8);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot(input bit use_pin);
    @(negedge mclk_in);
    if (use_pin) begin
      ext_en = 1'b1;
      ext_pin_n = 1'b0;
    end else begin
      rstn_in = 1'b0;
    end
    repeat (3) @(negedge mclk_in);
    chk(16'(phase), 16'h1);
    chk(16'(valid), 16'h0);
    chk(16'(pc), 16'h0);
    ext_pin_n = 1'b1;
    rstn_in = 1'b1;
    sync_p1();
    chk(16'(pc), 16'h1);
    chk(16'(valid), 16'h0);
    repeat (4) @(negedge mclk_in);
    chk(16'(ir), 16'(PM.word_at(8'h00)));
    chk(16'(valid), 16'h1);
    chk(16'(pc), 16'h2);
    ea = 8'h00;
  endtask

  // branch request held over phases two and three must be ignored
  task automatic t_phases();
    logic [FPS_WORD_W-1:0] held;
    held = ir;
    for (int k = 0; k < 4; k++) begin
      chk(16'(phase), 16'(4'h8 >> k));
      chk(16'({strobe.rd, strobe.wr}), 16'({k == 1, k == 3}));
      chk(16'(ir), 16'(held));
      pc_load = (k == 1 || k == 2);
      pc_target = 9'h055;
      @(negedge mclk_in);
    end
    ea = ea + 8'h01;
    chk(16'(ir), 16'(PM.word_at(ea)));
    chk(16'(valid), 16'h1);
  endtask

  // a second request in the flushed slot must be ignored
  task automatic t_branch(input logic [FPS_PC_W-1:0] tgt);
    repeat (3) @(negedge mclk_in);
    pc_load = 1'b1;
    pc_target = tgt;
    @(negedge mclk_in);
    pc_load = 1'b0;
    chk(16'(valid), 16'h0);
    chk(16'(pc), 16'(tgt + 9'h001));
    repeat (3) @(negedge mclk_in);
    pc_load = 1'b1;
    pc_target = 9'h033;
    @(negedge mclk_in);
    pc_load = 1'b0;
    ea = tgt[7:0];
    chk(16'(valid), 16'h1);
    chk(16'(ir), 16'(PM.word_at(ea)));
  endtask

  initial begin
    #(40 * 2000);
    mismatches++;
    finish_test();
  end

  initial begin
    // core stays in reset while the array is loaded, so no unknown word is fetched
    repeat (3) @(negedge mclk_in);
    PM.load_all();
    t_boot(1'b0);
    t_phases();
    t_phases();
    t_branch(9'h1fe);
    t_phases();
    t_phases();
    t_branch(9'h0a0);
    // pin low while not configured as reset: execution goes on
    ext_pin_n = 1'b0;
    t_phases();
    t_phases();
    ext_pin_n = 1'b1;
    t_boot(1'b1);
    t_phases();
    finish_test();
  end
endmodule
`default_nettype wire
